// ---- rpsp_char.sv ----
// Purpose: one-character serial shifter, transmit and receive
// Assumes: bit period in clock cycles from the caller, line idles high
// Notes:   transmit and receive run independently; the caller gates i_rx_enable for half-duplex
`timescale 1ns/1ns
`default_nettype none
`include "rpsp_params.svh"
module rpsp_char
(
  input  wire logic        i_clk,
  input  wire logic        i_reset,
  input  wire logic [15:0] i_bit_cycles,
  input  wire logic [1:0]  i_width,
  input  wire logic [1:0]  i_parity,
  input  wire logic [1:0]  i_stop,
  input  wire logic        i_tx_start,
  input  wire logic [7:0]  i_tx_data,
  output logic             o_tx_busy,
  output logic             o_tx_line,
  input  wire logic        i_rx_line,
  input  wire logic        i_rx_enable,
  output logic             o_rx_valid,
  output logic      [7:0]  o_rx_data,
  output logic             o_rx_error,
  output logic             o_rx_busy
);
  // Half-bit units: start 2, data 2 each, parity 2, stop 2/3/4
  logic [4:0]  tx_half_q;
  logic [15:0] tx_cnt_q;
  logic [11:0] tx_sr_q;
  logic [4:0]  rx_bit_q;
  logic [15:0] rx_cnt_q;
  logic [9:0]  rx_sr_q;
  wire  [3:0]  nbits;
  wire  [4:0]  rx_total;
  wire  [15:0] half_cycles;
  wire         par_bit;
  function automatic logic parity_of(input logic [7:0] d, input logic [3:0] n,
                                     input logic [1:0] p);
    logic acc;
    acc = 1'b0;
    for (int i = 0; i < 8; i++)
      if (4'(i) < n)
        acc = acc ^ d[i];
    parity_of = (p == 2'h1) ? ~acc : acc; // Odd inverts
  endfunction
  assign nbits       = 4'h5 + {2'b00, i_width};
  assign half_cycles = {1'b0, i_bit_cycles[15:1]};
  // parity slot sent as one when disabled
  assign par_bit     = (i_parity == 2'h0) ? 1'b1 :
                       parity_of(i_tx_data, nbits, i_parity);
  assign rx_total    = 5'(nbits) + ((i_parity != 2'h0) ? 5'h2 : 5'h1);
  assign o_tx_busy   = (tx_half_q != 5'h0);
  assign o_rx_busy   = (rx_bit_q != 5'h0);
  // Transmit shifter in half-bit steps, LSB first
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      tx_half_q <= 5'h0;
      tx_cnt_q  <= 16'h0;
      tx_sr_q   <= 12'hFFF;
      o_tx_line <= 1'b1;
    end
    else if (!o_tx_busy)
    begin
      o_tx_line <= 1'b1;
      if (i_tx_start)
      begin
        // start, data, parity, stop
        tx_sr_q   <= ({4'hF, i_tx_data} & ~(12'hFFF << nbits)) |
                     (12'hFFF << (nbits + 4'h1)) |
                     (12'(par_bit) << nbits);
        tx_half_q <= 5'((nbits + 4'h2) * 2) + 5'(i_stop) + 5'h1;
        tx_cnt_q  <= half_cycles;
        o_tx_line <= 1'b0;
      end
    end
    else if (tx_cnt_q > 16'h1)
      tx_cnt_q <= tx_cnt_q - 16'h1;
    else
    begin
      tx_cnt_q  <= half_cycles;
      tx_half_q <= tx_half_q - 5'h1;
      if (tx_half_q[0])
      begin
        o_tx_line <= tx_sr_q[0];
        tx_sr_q   <= {1'b1, tx_sr_q[11:1]};
      end
    end
  end
  // Receiver samples mid-bit after a start edge
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      rx_bit_q   <= 5'h0;
      rx_cnt_q   <= 16'h0;
      rx_sr_q    <= 10'h0;
      o_rx_valid <= 1'b0;
      o_rx_data  <= 8'h00;
      o_rx_error <= 1'b0;
    end
    else
    begin
      o_rx_valid <= 1'b0;
      if (!o_rx_busy)
      begin
        if (i_rx_enable && !i_rx_line)
        begin
          rx_bit_q <= rx_total + 5'h1;
          rx_cnt_q <= half_cycles;
        end
      end
      else if (rx_cnt_q > 16'h1)
        rx_cnt_q <= rx_cnt_q - 16'h1;
      else
      begin
        rx_cnt_q <= i_bit_cycles;
        rx_bit_q <= rx_bit_q - 5'h1;
        if (rx_bit_q == rx_total + 5'h1)
        begin
          if (i_rx_line)
            rx_bit_q <= 5'h0; // False start
        end
        else if (rx_bit_q != 5'h1)
          rx_sr_q <= {rx_sr_q[8:0], i_rx_line};
        else
        begin
          o_rx_valid <= 1'b1;
          o_rx_data  <= rx_bad_fn(rx_sr_q, nbits, i_parity != 2'h0);
          // Stop low, or bad parity when enabled
          o_rx_error <= !i_rx_line ||
            ((i_parity != 2'h0) && (rx_sr_q[0] !=
              parity_of(rx_bad_fn(rx_sr_q, nbits, 1'b1), nbits, i_parity)));
        end
      end
    end
  end
  // Reverse collected bits into an LSB-first byte
  function automatic logic [7:0] rx_bad_fn(input logic [9:0] sr,
                                           input logic [3:0] n,
                                           input logic       hp);
    logic [7:0] r;
    logic [9:0] s;
    r = 8'h00;
    s = hp ? {1'b0, sr[9:1]} : sr;
    for (int i = 0; i < 8; i++)
      if (4'(i) < n)
        r[i] = s[n - 4'(i) - 4'h1];
    rx_bad_fn = r;
  endfunction
endmodule
`default_nettype wire

// ---- rpsp_fifo.sv ----
// Purpose: byte FIFO of 2048 entries in one memory
// Assumes: single clock, synchronous reset
// Notes:   push when full and pop when empty are ignored
`timescale 1ns/1ns
`default_nettype none
`include "rpsp_params.svh"
module rpsp_fifo
(
  input  wire logic       i_clk,
  input  wire logic       i_reset,
  input  wire logic       i_push,
  input  wire logic [7:0] i_data,
  input  wire logic       i_pop,
  output logic      [7:0] o_data,
  output logic            o_empty,
  output logic            o_full
);
  logic [7:0]                 mem [0:`RPSP_FIFO_DEPTH-1];
  logic [`RPSP_FIFO_AW:0]     wr_q;
  logic [`RPSP_FIFO_AW:0]     rd_q;
  wire                        do_push;
  wire                        do_pop;
  // Pointer compare gives honest full and empty
  assign o_empty = (wr_q == rd_q);
  assign o_full  = (wr_q[`RPSP_FIFO_AW] != rd_q[`RPSP_FIFO_AW]) &&
                   (wr_q[`RPSP_FIFO_AW-1:0] == rd_q[`RPSP_FIFO_AW-1:0]);
  assign do_push = i_push && !o_full;
  assign do_pop  = i_pop && !o_empty;
  assign o_data  = mem[rd_q[`RPSP_FIFO_AW-1:0]];
  // Storage, no reset needed
  always_ff @(posedge i_clk)
  begin
    if (do_push)
      mem[wr_q[`RPSP_FIFO_AW-1:0]] <= i_data;
  end
  // Pointers
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      wr_q <= '0;
      rd_q <= '0;
    end
    else
    begin
      if (do_push)
        wr_q <= wr_q + 1'b1;
      if (do_pop)
        rd_q <= rd_q + 1'b1;
    end
  end
endmodule
`default_nettype wire

// ---- rpsp_params.svh ----
// Purpose: constants for the point-to-point serial port
// Assumes: 50 MHz clock, Avalon-MM register bus, word addresses
// Notes:   definitions only
`ifndef RPSP_PARAMS_SVH
`define RPSP_PARAMS_SVH
`define RPSP_CLK_HZ        50000000
`define RPSP_FIFO_DEPTH    2048
`define RPSP_FIFO_AW       11
// Register word addresses
`define RPSP_REG_CTRL      4'h0
`define RPSP_REG_CFG       4'h1
`define RPSP_REG_TXDATA    4'h2
`define RPSP_REG_RXDATA    4'h3
`define RPSP_REG_STATUS    4'h4
`define RPSP_REG_IRQ_STAT  4'h5
`define RPSP_REG_IRQ_MASK  4'h6
`define RPSP_REG_TIMEOUT   4'h7
// Configuration field positions
`define RPSP_CFG_PROTO_LSB 0
`define RPSP_CFG_BAUD_LSB  8
`define RPSP_CFG_WIDTH_LSB 16
`define RPSP_CFG_PAR_LSB   20
`define RPSP_CFG_STOP_LSB  24
`define RPSP_CFG_HS_LSB    28
// Baud codes
`define RPSP_BAUD_MIN      8'h04
`define RPSP_BAUD_MAX      8'h0E
// Result word codes
`define RPSP_RES_OK        16'h0000
`define RPSP_RES_PROTO     16'h8091
`define RPSP_RES_BAUD      16'h8093
`define RPSP_RES_WIDTH     16'h8094
`define RPSP_RES_PAR       16'h8095
`define RPSP_RES_STOP      16'h8096
// Reset configuration: ASCII, 9600, 8N1
`define RPSP_CFG_RESET     32'h01030901
`define RPSP_TIMEOUT_RESET 16'h009A
// Interrupt bit positions
`define RPSP_IRQ_RXAVAIL   0
`define RPSP_IRQ_TXDONE    1
`define RPSP_IRQ_ACK       2
`define RPSP_IRQ_TIMEOUT   3
`define RPSP_IRQ_OVERRUN   4
`define RPSP_IRQ_FRAMEERR  5
`define RPSP_IRQ_W         6
`endif

// ---- rpsp_partner.sv ----
// Purpose: remote station on the half-duplex pair
// Assumes: 8 data bits, parity slot, one stop, idle-high biasing
// Notes:   bit time in clock cycles
`timescale 1ns/1ns
`default_nettype none
module rpsp_partner
#(
  parameter int BIT = 434
)
(
  input  wire logic       i_clk,
  input  wire logic       i_tx,
  input  wire logic       i_oe,
  output logic            o_rx,
  output logic      [8:0] o_word,
  output logic      [7:0] o_cnt
);
  // Capture a character mid-bit, parity slot included
  initial
  begin
    o_rx = 1'b1;
    o_cnt = 8'h0;
    forever
    begin
      @(negedge i_tx iff i_oe);
      repeat (BIT / 2) @(posedge i_clk);
      for (int k = 0; k < 9; k++)
      begin
        repeat (BIT) @(posedge i_clk);
        o_word[k] = i_tx;
      end
      o_cnt = o_cnt + 8'h1;
    end
  end
  // Reply after a gap, never while the port drives the pair
  task automatic send(input logic [7:0] b, input logic [7:0] gap);
    logic [10:0] f;
    f = {2'b11, b, 1'b0};
    repeat (gap) @(posedge i_clk);
    for (int k = 0; k < 11; k++)
    begin
      o_rx <= i_oe ? 1'b1 : f[k];
      repeat (BIT) @(posedge i_clk);
    end
  endtask
endmodule
`default_nettype wire

// ---- rpsp_pkg.sv ----
// Purpose: types for the point-to-point serial port
// Assumes: nothing
// Notes:   constants live in rpsp_params.svh
package rpsp_pkg;
  typedef enum logic [2:0]
  {
    PR_NONE, PR_ASCII, PR_STXETX, PR_3964R,
    PR_USS, PR_MODBUS_RTU, PR_MODBUS_ASCII, PR_BAD
  } rpsp_proto_t;
  typedef enum logic [1:0] {PAR_NONE, PAR_ODD, PAR_EVEN, PAR_BAD} rpsp_par_t;
  // Send sequencer states: idle, payload, closing mark
  typedef enum logic [1:0] {TX_IDLE, TX_BODY, TX_TAIL} rpsp_txph_t;
endpackage

// ---- rpsp_sva.sv ----
// Purpose: port checks for the serial port
// Assumes: one clock, synchronous reset
// Notes:   bound to rpsp_top
`timescale 1ns/1ns
`default_nettype none
module rpsp_sva
(
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic o_avs_waitrequest,
  input wire logic o_line_tx,
  input wire logic o_line_oe,
  input wire logic o_dir_rts,
  input wire logic o_irq
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  // Bus answers one cycle after a fresh request, for one cycle only
  wait_low_a: assert property
    ($rose(i_avs_read | i_avs_write) |=> !o_avs_waitrequest) else $error("late");
  wait_one_a: assert property
    (!o_avs_waitrequest |=> o_avs_waitrequest) else $error("long answer");
  // Line and direction pins
  dir_rts_a: assert property (o_dir_rts == o_line_oe)
    else $error("rts differs");
  idle_high_a: assert property (!o_line_oe |-> o_line_tx)
    else $error("idle low");
  oe_hold_a: assert property ($rose(o_line_oe) |=> o_line_oe [*8])
    else $error("short drive");
  low_hold_a: assert property ($fell(o_line_tx) |=> !o_line_tx [*8])
    else $error("short low bit");
  high_hold_a: assert property ($rose(o_line_tx) |=> o_line_tx [*8])
    else $error("short high bit");
  reset_out_a: assert property
    ($fell(i_reset) |-> o_avs_waitrequest && !o_line_oe && !o_irq)
    else $error("reset state");
endmodule
bind rpsp_top rpsp_sva i_sva (.i_clk, .i_reset, .i_avs_read, .i_avs_write,
  .o_avs_waitrequest, .o_line_tx, .o_line_oe, .o_dir_rts, .o_irq);
`default_nettype wire

// ---- rpsp_tb_top.sv ----
// Purpose: self-checking bench for the serial port
// Assumes: 50 MHz clock, partner at 115200 baud
// Notes:   LFSR seed is fixed
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, s) begin n_checks++; if ((s) !== (e)) begin n_errors++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, s); end end
module rpsp_tb_top;
  logic        i_clk = 0, i_reset = 1, i_avs_read = 0, i_avs_write = 0;
  logic [3:0]  i_avs_address = 4'h0;
  logic [31:0] i_avs_writedata = 32'h0, o_avs_readdata, d;
  logic [31:0] seed = 32'hD09E57AE;
  logic        o_avs_waitrequest, o_line_tx, o_line_oe, o_dir_rts, o_irq;
  logic        p_rx;
  logic [8:0]  p_word;
  logic [7:0]  p_cnt, b;
  logic [47:0] c;
  int          n_errors = 0, n_checks = 0;
  wire logic   line_rx = o_line_oe ? o_line_tx : p_rx;
  rpsp_top i_dut (.i_clk, .i_reset, .i_avs_address, .i_avs_read, .i_avs_write,
    .i_avs_writedata, .o_avs_readdata, .o_avs_waitrequest, .i_line_rx(line_rx),
    .o_line_tx, .o_line_oe, .o_dir_rts, .o_irq);
  rpsp_partner i_par (.i_clk, .i_tx(line_rx), .i_oe(o_line_oe), .o_rx(p_rx),
    .o_word(p_word), .o_cnt(p_cnt));
  initial
    forever #10 i_clk = ~i_clk;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Config word and expected result code
  function automatic logic [47:0] cfg_case(input int k);
    case (k)
      8: return {32'h01030301, 16'h8093};
      9: return {32'h01030F01, 16'h8093};
      10: return {32'h02030E01, 16'h8096};
      default: return {24'h01030E, k[7:0],
        (k >= 1 && k <= 6) ? 16'h0000 : 16'h8091};
    endcase
  endfunction
  task automatic final_report();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // One Avalon access, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] w);
    int i;
    @(posedge i_clk);
    i_avs_read <= !wr;
    i_avs_write <= wr;
    i_avs_address <= a;
    i_avs_writedata <= w;
    for (i = 0; i < 50; i++)
    begin
      @(posedge i_clk);
      if (o_avs_waitrequest === 1'b0)
        break;
    end
    d = o_avs_readdata;
    i_avs_read <= 1'b0;
    i_avs_write <= 1'b0;
    if (i == 50)
    begin
      n_errors++;
      final_report();
    end
  endtask
  // Bounded wait: 0 partner got a char, 1 pair released, 2 irq high
  task automatic wait_for(input int sel);
    int i;
    for (i = 0; i < 9000; i++)
    begin
      @(posedge i_clk);
      if ((sel == 0 ? p_cnt != 8'h0 : sel == 1 ? !o_line_oe : o_irq) === 1'b1)
        break;
    end
    if (i == 9000)
    begin
      n_errors++;
      final_report();
    end
  endtask
  initial
  begin
    repeat (10) @(posedge i_clk);
    i_reset <= 1'b0;
    bus(0, 4'h1, 0);
    `CHK("cfg", 32'h01030901, d)
    bus(0, 4'h7, 0);
    `CHK("timeout", 32'h0000009A, d)
    bus(0, 4'h9, 0);
    `CHK("unmapped", 32'h0, d)
    for (int k = 0; k < 11; k++)
    begin
      c = cfg_case(k);
      bus(1, 4'h1, c[47:16]);
      bus(0, 4'h0, 0);
      `CHK("result", c[15:0], d[15:0])
    end
    bus(1, 4'h1, 32'h01030E04);
    bus(1, 4'h6, 32'h00000007);
    seed = lfsr(seed);
    b = seed[7:0];
    bus(1, 4'h2, {24'h0, b});
    wait_for(0);
    `CHK("line char", {1'b1, b}, p_word)
    wait_for(1);
    wait_for(2);
    bus(0, 4'h4, 0);
    `CHK("ack wait", 1'b1, d[2])
    bus(0, 4'h5, 0);
    `CHK("irq sent", 6'h02, d[5:0])
    bus(1, 4'h6, 32'h00000002);
    seed = lfsr(seed);
    i_par.send(seed[7:0], seed[15:8]);
    repeat (4) @(posedge i_clk);
    `CHK("masked", 1'b0, o_irq)
    bus(1, 4'h6, 32'h00000007);
    wait_for(2);
    bus(0, 4'h4, 0);
    `CHK("acked", 2'b11, {d[3], d[1]})
    bus(0, 4'h5, 0);
    `CHK("irq rx", 6'h05, d[5:0])
    bus(0, 4'h3, 0);
    `CHK("reply", seed[7:0], d[7:0])
    bus(0, 4'h4, 0);
    `CHK("rx empty", 1'b0, d[1])
    `CHK("irq clr", 1'b0, o_irq)
    final_report();
  end
endmodule
`default_nettype wire

// ---- rpsp_top.sv ----
// Purpose: RS485 point-to-point serial port with Avalon-MM registers
// Assumes: 50 MHz i_clk, synchronous active-high i_reset
// Notes:   framing per protocol, send/receive FIFOs, sticky interrupts
`timescale 1ns/1ns
`default_nettype none
`include "rpsp_params.svh"
module rpsp_top
(
  input  wire logic        i_clk,
  input  wire logic        i_reset,
  input  wire logic [3:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  output logic      [31:0] o_avs_readdata,
  output logic             o_avs_waitrequest,
  input  wire logic        i_line_rx,
  output logic             o_line_tx,
  output logic             o_line_oe,
  output logic             o_dir_rts,
  output logic             o_irq
);
  // Registers
  logic [31:0] cfg_q;
  logic [15:0] result_q;
  logic [15:0] timeout_q;
  logic [7:0]  start1_q;
  logic [7:0]  end1_q;
  logic [`RPSP_IRQ_W-1:0] irq_stat_q;
  logic [`RPSP_IRQ_W-1:0] irq_mask_q;
  logic        ack_q;
  logic        pending_q;
  logic        tx_rej_q;
  logic        rx_rej_q;
  logic        frame_on_q;
  rpsp_pkg::rpsp_txph_t tx_phase_q;
  logic [15:0] idle_cnt_q;
  logic [2:0]  rx_sync_q;
  logic        rx_filt_q;
  logic        acc_q;
  logic        tx_go_q;
  logic [7:0]  tx_byte_q;
  rpsp_pkg::rpsp_proto_t proto;
  // Bit period in clock cycles for a baud code
  function automatic logic [15:0] bit_cycles_fn(input logic [7:0] code);
    logic [31:0] baud;
    unique case (code)
      8'h04:   baud = 32'd1200;
      8'h05:   baud = 32'd1800;
      8'h06:   baud = 32'd2400;
      8'h07:   baud = 32'd4800;
      8'h08:   baud = 32'd7200;
      8'h09:   baud = 32'd9600;
      8'h0A:   baud = 32'd14400;
      8'h0B:   baud = 32'd19200;
      8'h0C:   baud = 32'd38400;
      8'h0D:   baud = 32'd57600;
      default: baud = 32'd115200;
    endcase
    bit_cycles_fn = 16'(32'(`RPSP_CLK_HZ) / baud);
  endfunction
  ////////////////////////////////////////////////////////////////////////
  // Configuration decode
  wire [7:0]  w_proto = i_avs_writedata[`RPSP_CFG_PROTO_LSB +: 8];
  wire [7:0]  w_baud  = i_avs_writedata[`RPSP_CFG_BAUD_LSB +: 8];
  wire [3:0]  w_width = i_avs_writedata[`RPSP_CFG_WIDTH_LSB +: 4];
  wire [3:0]  w_par   = i_avs_writedata[`RPSP_CFG_PAR_LSB +: 4];
  wire [3:0]  w_stop  = i_avs_writedata[`RPSP_CFG_STOP_LSB +: 4];
  // Handshake field ignored
  wire [15:0] w_result =
    (w_proto < 8'h01 || w_proto > 8'h06) ? `RPSP_RES_PROTO :
    (w_baud < `RPSP_BAUD_MIN || w_baud > `RPSP_BAUD_MAX) ? `RPSP_RES_BAUD :
    (w_width > 4'h3) ? `RPSP_RES_WIDTH :
    (w_par > 4'h2) ? `RPSP_RES_PAR :
    (w_stop < 4'h1 || w_stop > 4'h3 ||
     (w_stop == 4'h2 && w_width != 4'h0)) ? `RPSP_RES_STOP :
    `RPSP_RES_OK;
  // no other port role is decoded
  assign proto = rpsp_pkg::rpsp_proto_t'(cfg_q[2:0]);
  wire        acked_proto = (proto == rpsp_pkg::PR_3964R) ||
                            (proto == rpsp_pkg::PR_USS) ||
                            (proto == rpsp_pkg::PR_MODBUS_RTU) ||
                            (proto == rpsp_pkg::PR_MODBUS_ASCII);
  wire        framed = (proto == rpsp_pkg::PR_STXETX);
  wire [15:0] bit_cyc = bit_cycles_fn(cfg_q[`RPSP_CFG_BAUD_LSB +: 8]);
  ////////////////////////////////////////////////////////////////////////
  // Bus decode, one wait cycle per access
  wire acc_now  = (i_avs_read || i_avs_write) && !acc_q;
  wire wr_cfg   = acc_now && i_avs_write && i_avs_address == `RPSP_REG_CFG;
  wire wr_tx    = acc_now && i_avs_write && i_avs_address == `RPSP_REG_TXDATA;
  wire wr_ctrl  = acc_now && i_avs_write && i_avs_address == `RPSP_REG_CTRL;
  wire wr_mask  = acc_now && i_avs_write &&
                  i_avs_address == `RPSP_REG_IRQ_MASK;
  wire wr_tmo   = acc_now && i_avs_write && i_avs_address == `RPSP_REG_TIMEOUT;
  wire rd_rx    = acc_now && i_avs_read && i_avs_address == `RPSP_REG_RXDATA;
  wire rd_st    = acc_now && i_avs_read && i_avs_address == `RPSP_REG_STATUS;
  wire rd_irq   = acc_now && i_avs_read &&
                  i_avs_address == `RPSP_REG_IRQ_STAT;
  ////////////////////////////////////////////////////////////////////////
  // FIFOs and shifter
  wire        txf_empty;
  wire        txf_full;
  wire [7:0]  txf_data;
  wire        rxf_empty;
  wire        rxf_full;
  wire [7:0]  rxf_data;
  wire        ch_busy;
  wire        ch_line;
  wire        ch_rx_valid;
  wire [7:0]  ch_rx_data;
  wire        ch_rx_err;
  wire        ch_rx_busy;
  wire        txf_pop = !ch_busy && !tx_go_q && !txf_empty &&
                        tx_phase_q == rpsp_pkg::TX_BODY;
  wire        rx_push = ch_rx_valid && !ch_rx_err;
  wire        line_rx_en = !frame_on_q && !ch_busy;
  rpsp_fifo u_txf
  (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_push  (wr_tx),
    .i_data  (i_avs_writedata[7:0]),
    .i_pop   (txf_pop),
    .o_data  (txf_data),
    .o_empty (txf_empty),
    .o_full  (txf_full)
  );
  rpsp_fifo u_rxf
  (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_push  (rx_push),
    .i_data  (ch_rx_data),
    .i_pop   (rd_rx),
    .o_data  (rxf_data),
    .o_empty (rxf_empty),
    .o_full  (rxf_full)
  );
  rpsp_char u_char
  (
    .i_clk        (i_clk),
    .i_reset      (i_reset),
    .i_bit_cycles (bit_cyc),
    .i_width      (cfg_q[`RPSP_CFG_WIDTH_LSB +: 2]),
    .i_parity     (cfg_q[`RPSP_CFG_PAR_LSB +: 2]),
    .i_stop       (cfg_q[`RPSP_CFG_STOP_LSB +: 2]),
    .i_tx_start   (tx_go_q),
    .i_tx_data    (tx_byte_q),
    .o_tx_busy    (ch_busy),
    .o_tx_line    (ch_line),
    .i_rx_line    (rx_filt_q),
    .i_rx_enable  (line_rx_en),
    .o_rx_valid   (ch_rx_valid),
    .o_rx_data    (ch_rx_data),
    .o_rx_error   (ch_rx_err),
    .o_rx_busy    (ch_rx_busy)
  );
  ////////////////////////////////////////////////////////////////////////
  // Read mux; status holds acknowledgement and rejections
  wire [31:0] status_w = {16'h0, result_q[15:8] == 8'h00 ? 8'h00 : 8'h80,
                          rx_rej_q, tx_rej_q, ch_rx_busy, frame_on_q,
                          ack_q, pending_q, !rxf_empty, txf_full};
  wire [31:0] rd_mux =
    (i_avs_address == `RPSP_REG_CTRL)     ? {16'h0, result_q} :
    (i_avs_address == `RPSP_REG_CFG)      ? cfg_q :
    (i_avs_address == `RPSP_REG_RXDATA)   ? {24'h0, rxf_data} :
    (i_avs_address == `RPSP_REG_STATUS)   ? status_w :
    (i_avs_address == `RPSP_REG_IRQ_STAT) ? {26'h0, irq_stat_q} :
    (i_avs_address == `RPSP_REG_IRQ_MASK) ? {26'h0, irq_mask_q} :
    (i_avs_address == `RPSP_REG_TIMEOUT)  ? {16'h0, timeout_q} :
    32'h0;
  // Bus handshake and read data
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      acc_q             <= 1'b0;
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata    <= 32'h0;
    end
    else
    begin
      acc_q             <= acc_now;
      o_avs_waitrequest <= !acc_now;
      if (acc_now)
        o_avs_readdata <= rd_mux;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Configuration; a rejected setting is not stored
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      cfg_q     <= `RPSP_CFG_RESET;
      result_q  <= `RPSP_RES_OK;
      timeout_q <= `RPSP_TIMEOUT_RESET;
      start1_q  <= 8'h02;
      end1_q    <= 8'h03;
      irq_mask_q <= '0;
    end
    else
    begin
      if (wr_cfg)
      begin
        result_q <= w_result;
        if (w_result == `RPSP_RES_OK)
          cfg_q <= i_avs_writedata;
      end
      // Parameter block: timeout in bit periods, framing bytes
      if (wr_tmo)
        timeout_q <= i_avs_writedata[15:0];
      if (wr_ctrl)
      begin
        start1_q <= i_avs_writedata[23:16];
        end1_q   <= i_avs_writedata[31:24];
      end
      if (wr_mask)
        irq_mask_q <= i_avs_writedata[`RPSP_IRQ_W-1:0];
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Send sequencer: idle, payload, end mark; start mark on entry
  wire tx_idle   = !ch_busy && !tx_go_q;
  wire frame_end = tx_idle && tx_phase_q == rpsp_pkg::TX_BODY && txf_empty;
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      tx_phase_q <= rpsp_pkg::TX_IDLE;
      tx_go_q    <= 1'b0;
      tx_byte_q  <= 8'h00;
      frame_on_q <= 1'b0;
    end
    else
    begin
      tx_go_q <= 1'b0;
      unique case (tx_phase_q)
        rpsp_pkg::TX_IDLE:
          if (!txf_empty && !ch_rx_busy)
          begin
            tx_phase_q <= rpsp_pkg::TX_BODY;
            frame_on_q <= 1'b1;
            if (framed && start1_q < 8'h20)
            begin
              tx_go_q   <= 1'b1;
              tx_byte_q <= start1_q;
            end
          end
        rpsp_pkg::TX_BODY:
          if (txf_pop)
          begin
            tx_go_q   <= 1'b1;
            tx_byte_q <= txf_data;
          end
          else if (frame_end)
          begin
            tx_phase_q <= rpsp_pkg::TX_TAIL;
            if (framed && end1_q < 8'h20)
            begin
              tx_go_q   <= 1'b1;
              tx_byte_q <= end1_q;
            end
          end
        default:
          if (tx_idle)
          begin
            tx_phase_q <= rpsp_pkg::TX_IDLE;
            frame_on_q <= 1'b0;
          end
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Acknowledgement wait, timeout counted in bit periods
  wire sent_done = tx_phase_q == rpsp_pkg::TX_TAIL && tx_idle;
  wire bit_tick;
  logic [15:0] tick_q;
  assign bit_tick = (tick_q == 16'h0);
  wire tmo_hit = pending_q && bit_tick && idle_cnt_q >= timeout_q;
  wire ack_in  = pending_q && ch_rx_valid && !ch_rx_err;
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      pending_q  <= 1'b0;
      ack_q      <= 1'b0;
      idle_cnt_q <= 16'h0;
      tick_q     <= 16'h0;
    end
    else
    begin
      tick_q <= bit_tick ? bit_cyc - 16'h1 : tick_q - 16'h1;
      if (sent_done && acked_proto)
      begin
        pending_q  <= 1'b1;
        ack_q      <= 1'b0;
        idle_cnt_q <= 16'h0;
      end
      else if (ack_in)
      begin
        pending_q <= 1'b0; // Reply goes to the receive FIFO
        ack_q     <= 1'b1;
      end
      else if (tmo_hit)
        pending_q <= 1'b0;
      else if (pending_q && bit_tick)
        idle_cnt_q <= idle_cnt_q + 16'h1;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Rejection flags, cleared by a status read; set wins over clear
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      tx_rej_q <= 1'b0;
      rx_rej_q <= 1'b0;
    end
    else
    begin
      tx_rej_q <= (wr_tx && txf_full) || (tx_rej_q && !rd_st);
      rx_rej_q <= (rx_push && rxf_full) || (rx_rej_q && !rd_st);
    end
  end
  // Sticky interrupt status, read clears, new event wins
  wire [`RPSP_IRQ_W-1:0] irq_ev = {ch_rx_valid && ch_rx_err,
                                   (rx_push && rxf_full) ||
                                   (wr_tx && txf_full),
                                   tmo_hit, ack_in, sent_done, rx_push};
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      irq_stat_q <= '0;
      o_irq      <= 1'b0;
    end
    else
    begin
      irq_stat_q <= irq_ev | (rd_irq ? '0 : irq_stat_q);
      o_irq      <= |(irq_stat_q & irq_mask_q);
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Line pins: three-stage input sync, drive only while sending
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      rx_sync_q <= 3'b111;
      rx_filt_q <= 1'b1;
      o_line_tx <= 1'b1;
      o_line_oe <= 1'b0;
      o_dir_rts <= 1'b0;
    end
    else
    begin
      rx_sync_q <= {rx_sync_q[1:0], i_line_rx};
      if (rx_sync_q[1] == rx_sync_q[2])
        rx_filt_q <= rx_sync_q[2];
      o_line_tx <= ch_line;
      o_line_oe <= frame_on_q;
      o_dir_rts <= frame_on_q;
    end
  end
endmodule
`default_nettype wire
